// [inc/thermal_monitor_pkg.sv]
/*
 * Constants and types for the thermal monitor register set: pointer codes,
 * configuration field layout, serial bus framing counts and reset values.
 * Assumes a SystemVerilog-2012 compiler; no timing here.
 */
package thermal_monitor_pkg;

    // ****************************************************************
    // Data formats
    // ****************************************************************
    localparam int TEMP_W = 9;                  // Half-degree two's-complement code
    localparam int REG16_W = 16;
    localparam int BYTE_W = 8;
    localparam int QCNT_W = 3;

    // Pointer selections, low two bits of the selector
    localparam logic [1:0] PTR_TEMP = 2'h0;
    localparam logic [1:0] PTR_CONFIG = 2'h1;
    localparam logic [1:0] PTR_HYST = 2'h2;
    localparam logic [1:0] PTR_SETPOINT = 2'h3;

    // Fixed upper device address bits on the two-wire bus
    localparam logic [3:0] DEV_PREFIX = 4'h9;
    localparam int ADDR_SEL_W = 3;

    // Bit slot counts within one byte frame
    localparam logic [3:0] BIT_LAST = 4'h7;     // Eighth data bit
    localparam logic [3:0] BIT_ACK = 4'h8;      // Acknowledge slot
    localparam logic [1:0] IDX_FIRST = 2'h1;    // First data byte after pointer
    localparam logic [1:0] IDX_SECOND = 2'h2;

    // Fault queue encodings to required consecutive results
    localparam logic [1:0] FQ_ONE = 2'h0;
    localparam logic [1:0] FQ_TWO = 2'h1;
    localparam logic [1:0] FQ_FOUR = 2'h2;
    localparam logic [QCNT_W-1:0] NEED_1 = 3'h1;
    localparam logic [QCNT_W-1:0] NEED_2 = 3'h2;
    localparam logic [QCNT_W-1:0] NEED_4 = 3'h4;
    localparam logic [QCNT_W-1:0] NEED_6 = 3'h6;
    localparam logic [QCNT_W-1:0] QCNT_MAX = 3'h7;

    // Reset values of thresholds and temperature
    localparam logic [TEMP_W-1:0] SETPOINT_RST = 9'h0C8;
    localparam logic [TEMP_W-1:0] HYST_RST = 9'h0B4;
    localparam logic [TEMP_W-1:0] TEMP_RST = 9'h000;

    // Configuration register fields
    typedef struct packed {
        logic [2:0] zero;       // Reserved, always zero
        logic [1:0] queue;      // Fault queue depth code
        logic level;            // Alarm active level
        logic mode;             // 0 comparator, 1 interrupt
        logic shutdown;         // 1 stops conversions
    } cfg_t;
    localparam cfg_t CFG_RST = '{zero: 3'h0, queue: 2'h0, level: 1'b0, mode: 1'b0,
                                 shutdown: 1'b0};

    // Open-drain data pin as one drive-low signal
    typedef struct packed {
        logic drive_low;        // Output enable, pin pulled low
    } od_pin_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WRITE,
        ST_READ
    } bus_state_t;

endpackage

// [sim/host_master_model.sv]
/* Two-wire bus master model that drives the sensor's clock and data lines.
   Assumes a pull-up on data and a device that only ever pulls data low. */
`timescale 1ns/1ps
`default_nettype none

module host_master_model (
    input wire logic clk_in,    // System clock
    input wire logic oe_in,     // Device pulls data low
    output logic scl_out,       // Bus clock level
    output logic sda_out        // Resolved data wire
);
    // ****************************************************************
    // Wire and phases
    // ****************************************************************
    localparam int HALF = 8;    // Clocks per bus phase, well above the sync delay
    logic drv_r;                // Host data drive, 1 = released

    // Pull-up wins unless either party pulls low
    assign sda_out = drv_r & ~oe_in;

    initial begin
        scl_out = 1'b1;
        drv_r = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Data raised before the clock, so this also serves as a repeated start
    task automatic start_cond();
        @(posedge clk_in);
        drv_r <= 1'b1;
        hold(HALF);
        scl_out <= 1'b1;
        hold(HALF);
        drv_r <= 1'b0;
        hold(HALF);
        scl_out <= 1'b0;
        hold(HALF);
    endtask

    task automatic stop_cond();
        drv_r <= 1'b0;
        hold(HALF);
        scl_out <= 1'b1;
        hold(HALF);
        drv_r <= 1'b1;
        hold(HALF);
    endtask

    // Data changes only while the clock is low; sampled mid-high
    task automatic bit_slot(input logic b, output logic s);
        drv_r <= b;
        hold(HALF);
        scl_out <= 1'b1;
        hold(HALF / 2);
        s = sda_out;
        hold(HALF / 2);
        scl_out <= 1'b0;
        hold(HALF);
    endtask

    // Most significant bit first, then the acknowledge slot
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(d[i], s);
        end
        bit_slot(1'b1, s);
        ack = ~s;
    endtask

    // Host answers with a not-acknowledge on the last byte
    task automatic read_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, s);
            d[i] = s;
        end
        bit_slot(last, s);
    endtask
endmodule

`default_nettype wire

// [sim/thermal_monitor_regs_tb_top.sv]
/* Self-checking bench for the thermal monitor register set.
   Assumes the host model in the same folder and the package on the include path. */
`timescale 1ns/1ps
`default_nettype none

module thermal_monitor_regs_tb_top
    import thermal_monitor_pkg::*;
;
    // ****************************************************************
    // Clock, reset and wiring
    // ****************************************************************
    localparam logic [ADDR_SEL_W-1:0] SEL = 3'h5;
    localparam logic [7:0] ADDR_W = {DEV_PREFIX, SEL, 1'b0};
    logic clk_in = 1'b0;
    logic rst_in;
    logic [TEMP_W-1:0] sample;
    logic valid;
    logic [ADDR_SEL_W-1:0] straps;
    wire scl, sda, oe, conv_en, pin, sda_drv;
    int failures;
    int n_tests;

    always #2.5 clk_in = ~clk_in;

    thermal_monitor_regs DUT (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_drv), .sda_oe_out(oe), .addr_sel_in(straps), .temp_sample_in(sample),
        .temp_valid_in(valid), .conv_enable_out(conv_en), .thermal_alarm_output_out(pin));
    host_master_model host (.clk_in(clk_in), .oe_in(oe), .scl_out(scl), .sda_out(sda));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wb(input logic [7:0] v);
        logic a;
        host.write_byte(v, a);
        chk({15'h0000, a}, 16'h0001);
    endtask

    // Selector byte keeps its upper bits zero
    task automatic wr(input logic [1:0] p, input int n, input logic [15:0] d);
        host.start_cond();
        wb(ADDR_W);
        wb({6'h00, p});
        if (n > 0) wb(d[15:8]);
        if (n > 1) wb(d[7:0]);
        host.stop_cond();
    endtask

    task automatic rd(input logic [1:0] p, input int n, output logic [15:0] d);
        logic [7:0] b;
        wr(p, 0, 16'h0000);
        host.start_cond();
        wb(ADDR_W | 8'h01);
        host.read_byte(n == 1, b);
        d = {b, 8'h00};
        if (n > 1) begin
            host.read_byte(1'b1, b);
            d[7:0] = b;
        end
        host.stop_cond();
    endtask

    // One-cycle conversion pulse, then time for the alarm to settle
    task automatic conv(input logic [TEMP_W-1:0] v);
        @(posedge clk_in);
        sample <= v;
        valid <= 1'b1;
        @(posedge clk_in);
        valid <= 1'b0;
        @(posedge clk_in);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        logic [15:0] d;
        chk({15'h0000, conv_en}, 16'h0001);
        chk({15'h0000, pin}, 16'h0001);
        chk({15'h0000, sda_drv}, 16'h0000);
        rd(PTR_CONFIG, 1, d);
        chk(d, 16'h0000);
        rd(PTR_SETPOINT, 2, d);
        chk(d, {SETPOINT_RST, 7'h00});
        rd(PTR_HYST, 2, d);
        chk(d, {HYST_RST, 7'h00});
        $display("reset test done");
    endtask

    // Reserved bits written as ones must read back as zero
    task automatic t_config();
        logic [15:0] d;
        wr(PTR_CONFIG, 1, 16'hFF00);
        rd(PTR_CONFIG, 1, d);
        chk(d, 16'h1F00);
        chk({15'h0000, conv_en}, 16'h0000);
        wr(PTR_CONFIG, 1, 16'h0000);
        chk({15'h0000, conv_en}, 16'h0001);
        $display("config test done");
    endtask

    task automatic t_address();
        logic a;
        host.start_cond();
        host.write_byte({DEV_PREFIX, 3'h2, 1'b0}, a);
        chk({15'h0000, a}, 16'h0000);
        host.stop_cond();
        host.start_cond();
        host.write_byte({4'h8, SEL, 1'b0}, a);
        chk({15'h0000, a}, 16'h0000);
        host.stop_cond();
        // Straps moved: the formerly foreign address now belongs to the block
        straps <= 3'h2;
        host.start_cond();
        host.write_byte({DEV_PREFIX, 3'h2, 1'b0}, a);
        chk({15'h0000, a}, 16'h0001);
        host.stop_cond();
        straps <= SEL;
        $display("address test done");
    endtask

    // A lone high byte must not commit a 16-bit threshold
    task automatic t_thresh();
        logic [15:0] d;
        wr(PTR_SETPOINT, 2, {9'h0FA, 7'h00});
        wr(PTR_HYST, 2, {9'h192, 7'h00});
        wr(PTR_SETPOINT, 1, 16'h0000);
        rd(PTR_SETPOINT, 2, d);
        chk(d & 16'hFF80, 16'h7D00);
        rd(PTR_HYST, 2, d);
        chk(d & 16'hFF80, 16'hC900);
        wr(PTR_SETPOINT, 2, {9'h032, 7'h00});
        wr(PTR_HYST, 2, {9'h1CE, 7'h00});
        $display("threshold test done");
    endtask

    task automatic t_temp();
        logic [15:0] d;
        logic [8:0] codes [8] = '{9'h0FA, 9'h032, 9'h001, 9'h000, 9'h1FF, 9'h1CE, 9'h1B0,
            9'h192};
        foreach (codes[i]) begin
            conv(codes[i]);
            rd(PTR_TEMP, 2, d);
            chk(d & 16'hFF80, {codes[i], 7'h00});
        end
        wr(PTR_TEMP, 2, 16'h0000);
        rd(PTR_TEMP, 2, d);
        chk(d & 16'hFF80, 16'hC900);
        $display("temperature test done");
    endtask

    // Every queue depth, active-high pin, comparator mode; then interrupt mode with active-low pin
    task automatic t_alarm();
        int need [4] = '{1, 2, 4, 6};
        logic [15:0] d;
        wr(PTR_CONFIG, 1, 16'h0000);
        conv(9'h192);
        for (int q = 0; q < 4; q++) begin
            wr(PTR_CONFIG, 1, {3'h0, q[1:0], 3'h4, 8'h00});
            repeat (need[q] - 1) conv(9'h0FA);
            chk({15'h0000, pin}, 16'h0000);
            conv(9'h0FA);
            chk({15'h0000, pin}, 16'h0001);
            repeat (need[q] - 1) conv(9'h192);
            chk({15'h0000, pin}, 16'h0001);
            conv(9'h192);
            chk({15'h0000, pin}, 16'h0000);
        end
        wr(PTR_CONFIG, 1, 16'h0200);
        chk({15'h0000, pin}, 16'h0001);
        conv(9'h0FA);
        chk({15'h0000, pin}, 16'h0000);
        rd(PTR_CONFIG, 1, d);
        chk({15'h0000, pin}, 16'h0001);
        conv(9'h192);
        chk({15'h0000, pin}, 16'h0000);
        $display("alarm test done");
    endtask

    task automatic t_shutdown();
        logic [15:0] d;
        wr(PTR_CONFIG, 1, 16'h0100);
        chk({15'h0000, conv_en}, 16'h0000);
        conv(9'h001);
        rd(PTR_TEMP, 2, d);
        chk(d & 16'hFF80, 16'hC900);
        wr(PTR_CONFIG, 1, 16'h0000);
        chk({15'h0000, conv_en}, 16'h0001);
        $display("shutdown test done");
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        failures = 0;
        n_tests = 0;
        rst_in = 1'b1;
        sample = '0;
        valid = 1'b0;
        straps = SEL;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_config();
        t_address();
        t_thresh();
        t_temp();
        t_alarm();
        t_shutdown();
        end_of_test();
    end

    // Roughly three times the expected run length
    initial begin
        repeat (100000) @(posedge clk_in);
        failures++;
        end_of_test();
    end
endmodule

`default_nettype wire

// [verilog/thermal_monitor_regs.sv]
/*
 * Register set and alarm logic of a two-wire temperature sensor, with the
 * serial slave that reaches it through a register selector.
 * Assumes scl/sda inputs already synchronous to clk_in and much slower than
 * it, and a converter that pulses temp_valid_in with each new sample.
 */
//
// Behaviour
// - configuration bit 0 high stops conversions (shutdown), low runs normally
// - configuration bit 1 selects comparator (0) or interrupt (1) alarm mode
// - configuration bit 2 sets alarm active level, 0 low, 1 high
// - configuration bits 4:3 choose 1, 2, 4 or 6 consecutive results
// - configuration register is eight bits, readable and writable
// - temperature register loads each conversion result; writes do nothing
// - temperature is 16 bits, 9-bit value at bits 15:7, rest don't-care
// - values are two's complement half degrees, zero code is zero degrees
// - setpoint and hysteresis are 16-bit read-write, same layout as temperature
// - reference codes: 125 is 0FA, -0.5 is 1FF, -55 is 192
// - selector low bits pick temperature, configuration, hysteresis, setpoint
// - alarm changes only after the programmed run of consecutive results, or on a read in interrupt mode
// - responds only to address 1001 followed by the address select inputs
`timescale 1ns/1ps
`default_nettype none

module thermal_monitor_regs
    import thermal_monitor_pkg::*;
(
    input wire logic clk_in,                        // 200 MHz system clock
    input wire logic rst_in,                        // Async reset, active high
    input wire logic scl_in,                        // Bus clock level
    input wire logic sda_in,                        // Bus data level
    output logic sda_out,                           // Data drive value, always low
    output logic sda_oe_out,                        // High while pulling data low
    input wire logic [ADDR_SEL_W-1:0] addr_sel_in,  // Address select straps
    input wire logic [TEMP_W-1:0] temp_sample_in,   // Converter result
    input wire logic temp_valid_in,                 // Conversion complete pulse
    output logic conv_enable_out,                   // Converter run, low in shutdown
    output logic thermal_alarm_output_out           // Alarm pin level
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    cfg_t cfg_r;
    logic [TEMP_W-1:0] temp_r, setpoint_r, hyst_r;
    logic [BYTE_W-1:0] selector_r, rx_r, tx_r, hold_r;
    logic scl_q_r, sda_q_r, oe_r, rw_r, skip_r;
    logic [3:0] bit_r;
    logic [1:0] widx_r;
    logic ridx_r;
    bus_state_t state_r;
    logic [QCNT_W-1:0] hi_cnt_r, lo_cnt_r, need;
    logic alarm_r, expect_hi_r;

    // ****************************************************************
    // Bus condition decode
    // ****************************************************************
    wire scl_rise = scl_in & ~scl_q_r;
    wire scl_fall = ~scl_in & scl_q_r;
    wire start_cond = scl_in & scl_q_r & sda_q_r & ~sda_in;
    wire stop_cond = scl_in & scl_q_r & ~sda_q_r & sda_in;
    wire byte_done = scl_fall & (bit_r == BIT_LAST);
    wire ack_done = scl_fall & (bit_r == BIT_ACK);
    wire addr_match = (rx_r[7:4] == DEV_PREFIX) & (rx_r[3:1] == addr_sel_in);
    wire addr_ok = byte_done & (state_r == ST_ADDR) & addr_match;
    wire wr_byte = byte_done & (state_r == ST_WRITE);
    wire [1:0] ptr = selector_r[1:0];
    wire is_cfg = (ptr == PTR_CONFIG);
    wire cfg_wr = wr_byte & (widx_r == IDX_FIRST) & is_cfg;
    wire thr_wr = wr_byte & (widx_r == IDX_SECOND) & ptr[1];
    wire read_start = addr_ok & rx_r[0];

    // Read data: high byte first, then the LSB byte with zero don't-cares
    logic [TEMP_W-1:0] sel_val;
    assign sel_val = (ptr == PTR_TEMP) ? temp_r :
                     (ptr == PTR_HYST) ? hyst_r : setpoint_r;
    wire [BYTE_W-1:0] rd_byte = is_cfg ? cfg_r :
                                ridx_r ? {sel_val[0], 7'h00} : sel_val[TEMP_W-1:1];

    // Next transmit byte; read stops advancing after the second byte
    wire next_ridx = (state_r == ST_READ);
    wire [BYTE_W-1:0] next_tx = is_cfg ? cfg_r :
                                next_ridx ? {sel_val[0], 7'h00} : sel_val[TEMP_W-1:1];

    // ****************************************************************
    // Serial slave
    // ****************************************************************
    // Start wins over everything so a repeated start always re-frames
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            state_r <= ST_IDLE;
            bit_r <= 4'h0;
            oe_r <= 1'b0;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            rw_r <= 1'b0;
            widx_r <= 2'h0;
            ridx_r <= 1'b0;
            hold_r <= 8'h00;
            skip_r <= 1'b0;
        end else begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
            if (start_cond) begin
                state_r <= ST_ADDR;
                bit_r <= 4'h0;
                oe_r <= 1'b0;
                widx_r <= 2'h0;
                ridx_r <= 1'b0;
                skip_r <= 1'b1;
            end else if (stop_cond) begin
                state_r <= ST_IDLE;
                oe_r <= 1'b0;
            end else if (state_r != ST_IDLE) begin
                if (scl_rise && bit_r != BIT_ACK) begin
                    rx_r <= {rx_r[6:0], sda_in};
                end
                if (scl_rise && bit_r == BIT_ACK && state_r == ST_READ && sda_in) begin
                    state_r <= ST_IDLE;     // Host declined further bytes
                end
                if (byte_done) begin
                    bit_r <= BIT_ACK;
                    case (state_r)
                        ST_ADDR: begin
                            oe_r <= addr_match;
                            rw_r <= rx_r[0];
                            if (!addr_match) begin
                                state_r <= ST_IDLE;
                            end
                        end
                        ST_WRITE: begin
                            oe_r <= 1'b1;
                            if (widx_r == 2'h0) begin
                                hold_r <= rx_r;
                            end else if (widx_r == IDX_FIRST) begin
                                hold_r <= rx_r;                 // Upper half kept
                            end
                            if (widx_r != 2'h3) begin
                                widx_r <= widx_r + 2'h1;
                            end
                        end
                        default: oe_r <= 1'b0;                  // Host acks reads
                    endcase
                end else if (ack_done) begin
                    bit_r <= 4'h0;
                    case (state_r)
                        ST_ADDR: begin
                            state_r <= rw_r ? ST_READ : ST_WRITE;
                            tx_r <= rd_byte;
                            oe_r <= rw_r & ~rd_byte[7];
                        end
                        ST_READ: begin
                            ridx_r <= 1'b1;
                            tx_r <= next_tx;
                            oe_r <= ~next_tx[7];
                        end
                        default: oe_r <= 1'b0;
                    endcase
                end else if (scl_fall && skip_r) begin
                    skip_r <= 1'b0;     // Fall closing the start is no bit slot
                end else if (scl_fall && bit_r < BIT_LAST) begin
                    bit_r <= bit_r + 4'h1;
                    if (state_r == ST_READ) begin
                        tx_r <= {tx_r[6:0], 1'b0};
                        oe_r <= ~tx_r[6];
                    end
                end
            end
        end
    end

    // Pointer byte is the first byte of every write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            selector_r <= 8'h00;
        end else if (wr_byte && widx_r == 2'h0) begin
            selector_r <= rx_r;
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Reserved configuration bits are dropped; temperature is never written
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_r <= CFG_RST;
            setpoint_r <= SETPOINT_RST;
            hyst_r <= HYST_RST;
            temp_r <= TEMP_RST;
        end else begin
            if (cfg_wr) begin
                cfg_r <= {3'h0, rx_r[4:0]};
            end
            if (thr_wr && ptr == PTR_SETPOINT) begin
                setpoint_r <= {hold_r, rx_r[7]};
            end
            if (thr_wr && ptr == PTR_HYST) begin
                hyst_r <= {hold_r, rx_r[7]};
            end
            if (temp_valid_in && conv_enable_out) begin
                temp_r <= temp_sample_in;
            end
        end
    end

    // ****************************************************************
    // Fault queue and alarm
    // ****************************************************************
    assign need = (cfg_r.queue == FQ_ONE) ? NEED_1 :
                  (cfg_r.queue == FQ_TWO) ? NEED_2 :
                  (cfg_r.queue == FQ_FOUR) ? NEED_4 : NEED_6;
    wire sample = temp_valid_in & conv_enable_out;
    // Signed compare of the half-degree codes
    wire is_hi = $signed(temp_sample_in) > $signed(setpoint_r);
    wire is_lo = $signed(temp_sample_in) < $signed(hyst_r);
    wire [QCNT_W-1:0] hi_nxt = !is_hi ? 3'h0 : (hi_cnt_r == QCNT_MAX) ? QCNT_MAX :
                               hi_cnt_r + 3'h1;
    wire [QCNT_W-1:0] lo_nxt = !is_lo ? 3'h0 : (lo_cnt_r == QCNT_MAX) ? QCNT_MAX :
                               lo_cnt_r + 3'h1;
    wire qual_hi = sample & (hi_nxt >= need);
    wire qual_lo = sample & (lo_nxt >= need);

    // Interrupt mode: read clears, but a same-cycle event still wins
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hi_cnt_r <= 3'h0;
            lo_cnt_r <= 3'h0;
            alarm_r <= 1'b0;
            expect_hi_r <= 1'b1;
        end else begin
            if (sample) begin
                hi_cnt_r <= hi_nxt;
                lo_cnt_r <= lo_nxt;
            end
            if (!cfg_r.mode) begin
                expect_hi_r <= 1'b1;
                if (qual_hi) begin
                    alarm_r <= 1'b1;
                end else if (qual_lo) begin
                    alarm_r <= 1'b0;
                end
            end else if ((expect_hi_r && qual_hi) || (!expect_hi_r && qual_lo)) begin
                alarm_r <= 1'b1;
                expect_hi_r <= ~expect_hi_r;
            end else if (read_start) begin
                alarm_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sda_out = 1'b0;
    assign sda_oe_out = oe_r;
    assign conv_enable_out = ~cfg_r.shutdown;
    assign thermal_alarm_output_out = cfg_r.level ? alarm_r : ~alarm_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence addr_seen_s;
        state_r == ST_ADDR && byte_done;
    endsequence

    shutdown_stop_a: assert property (cfg_wr && rx_r[0] |=> !conv_enable_out)
        else $error("shutdown write did not stop conversions");
    temp_load_a: assert property (sample |=> temp_r == $past(temp_sample_in))
        else $error("temperature not loaded from conversion");
    temp_hold_a: assert property (!sample |=> $stable(temp_r))
        else $error("temperature changed without a conversion");
    alarm_level_a: assert property (thermal_alarm_output_out == (alarm_r ~^ cfg_r.level))
        else $error("alarm pin polarity wrong");
    queue_rise_a: assert property (!cfg_r.mode && $rose(alarm_r) |-> hi_cnt_r >= need)
        else $error("alarm rose before queue filled");
    cmp_fall_a: assert property (!cfg_r.mode && !$past(cfg_r.mode) && $fell(alarm_r)
                                 |-> lo_cnt_r >= need)
        else $error("comparator alarm cleared without low run");
    addr_nack_a: assert property (addr_seen_s and !addr_match
                                  |=> !sda_oe_out && state_r == ST_IDLE)
        else $error("acked a foreign address");
    addr_ack_a: assert property (addr_seen_s and addr_match |=> sda_oe_out [*1])
        else $error("own address not acknowledged");
    cfg_zero_a: assert property (cfg_r.zero == 3'h0)
        else $error("reserved configuration bits set");

endmodule

`default_nettype wire
